// file: rtl/rcr_defs.svh
// constants of the regulator control register block
`ifndef RCR_DEFS_SVH
`define RCR_DEFS_SVH

`define RCR_ADDR          8'hC9
`define RCR_RESET         8'h00
`define RCR_WR_MASK       8'hBF
`define RCR_BIT_INREG_DIS 7
`define RCR_BIT_BUS_PWR   6
`define RCR_BIT_RSVD_HI   5
`define RCR_BIT_INREG_LP  4
`define RCR_BIT_STOP_CFG  3
`define RCR_BIT_RSVD_LO   2
`define RCR_BIT_CORE_LP   1
`define RCR_BIT_MPC_EN    0
`define RCR_SKIP_CYCLES   5'h14
`define RCR_SKIP_LAST     5'h00
`define RCR_SKIP_STEP     5'h01

`endif

// file: rtl/rcr_mpc.sv
// program memory power controller with clock speed-up skip window
`timescale 1ns/100ps
`default_nettype none
`include "rcr_defs.svh"

module rcr_mpc (
  input wire logic CLK,
  input wire logic RST,
  rcr_mpc_if.mpc   bus
);

  rcr_pkg::rcr_mpc_state_e state_reg;
  rcr_pkg::rcr_skip_cnt_t  cnt_reg;
  logic                    fast_prev_reg;
  logic                    mem_on_reg;
  logic                    stall_reg;
  logic                    active;
  logic                    speed_up;

  // --------------------------------------------------------------
  // gating
  // --------------------------------------------------------------
  assign active   = bus.enable && !bus.prefetch_on; // R9
  assign speed_up = active && bus.ext_clk && bus.clk_fast
                    && !fast_prev_reg;

  always_ff @(posedge CLK)
  begin
    if (RST)
      fast_prev_reg <= 1'b0;
    else
      fast_prev_reg <= bus.clk_fast;
  end

  // --------------------------------------------------------------
  // skip window
  // --------------------------------------------------------------
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      state_reg <= rcr_pkg::RCR_MPC_IDLE;
      cnt_reg   <= `RCR_SKIP_LAST;
      stall_reg <= 1'b0;
    end
    else
    begin
      unique case (state_reg)
        rcr_pkg::RCR_MPC_IDLE:
        begin
          if (speed_up) // R10
          begin
            state_reg <= rcr_pkg::RCR_MPC_SKIP;
            cnt_reg   <= `RCR_SKIP_CYCLES - `RCR_SKIP_STEP;
            stall_reg <= 1'b1;
          end
        end
        rcr_pkg::RCR_MPC_SKIP:
        begin
          if (cnt_reg == `RCR_SKIP_LAST)
          begin
            state_reg <= rcr_pkg::RCR_MPC_IDLE;
            stall_reg <= 1'b0;
          end
          else
            cnt_reg <= cnt_reg - `RCR_SKIP_STEP;
        end
        default:
        begin
          state_reg <= rcr_pkg::RCR_MPC_IDLE;
          stall_reg <= 1'b0;
        end
      endcase
    end
  end

  // --------------------------------------------------------------
  // memory power
  // --------------------------------------------------------------
  always_ff @(posedge CLK)
  begin
    if (RST)
      mem_on_reg <= 1'b1;
    else
      mem_on_reg <= !active || bus.fetch || speed_up || stall_reg; // R8
  end

  assign bus.mem_on = mem_on_reg;
  assign bus.stall  = stall_reg;

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  a_mem_fetch_gate: assert property ( // R8
    active && !bus.fetch && !speed_up && !stall_reg |=> !mem_on_reg)
    else $error("memory powered while idle with controller on");

  a_prefetch_keeps_on: assert property ( // R9
    bus.prefetch_on |=> mem_on_reg)
    else $error("memory gated while prefetch engine is on");

  a_skip_length: assert property ( // R10
    $rose(stall_reg) |-> ##19 stall_reg ##1 !stall_reg)
    else $error("skip window is not twenty cycles");

  a_skip_mem_on: assert property ( // R10
    stall_reg |=> mem_on_reg)
    else $error("memory gated during skip window");

  c_skip_seen: cover property ($rose(stall_reg));
  c_gated: cover property (active ##1 !mem_on_reg);

endmodule : rcr_mpc

`default_nettype wire

// file: rtl/rcr_mpc_if.sv
// link between register bank and memory power controller
`timescale 1ns/100ps
`default_nettype none

interface rcr_mpc_if;
  logic enable;
  logic prefetch_on;
  logic fetch;
  logic clk_fast;
  logic ext_clk;
  logic mem_on;
  logic stall;

  modport ctl (
    output enable,
    output prefetch_on,
    output fetch,
    output clk_fast,
    output ext_clk,
    input  mem_on,
    input  stall
  );

  modport mpc (
    input  enable,
    input  prefetch_on,
    input  fetch,
    input  clk_fast,
    input  ext_clk,
    output mem_on,
    output stall
  );
endinterface : rcr_mpc_if

`default_nettype wire

// file: rtl/rcr_pkg.sv
// types of the regulator control register block
package rcr_pkg;

  typedef enum logic [1:0] {
    RCR_MPC_IDLE = 2'h0,
    RCR_MPC_SKIP = 2'h1
  } rcr_mpc_state_e;

  typedef logic [4:0] rcr_skip_cnt_t;

endpackage : rcr_pkg

// file: rtl/rcr_top.sv
// regulator control register bank on the special function register bus
//
// Behaviour
// (R1) Bit 7 written 1 disables the input regulator, 0 keeps it on.
// (R2) Bit 6 is read-only and shows the synchronised bus-power level.
// (R3) Software writes zero to reserved bits 5 and 2.
// (R4) Bit 4 puts the input regulator in low-power suspend mode.
// (R5) Bit 3 set shuts the core regulator down in stop state.
// (R6) Bit 1 puts the core regulator in low-power mode.
// (R7) Software leaves bit 1 clear while the input regulator is off.
// (R8) Bit 0 set powers program memory down in cycles without a fetch.
// (R9) Bit 0 has no effect while the prefetch engine is on.
// (R10) A slow-to-fast external clock change stalls fetch 20 cycles.
// (R11) Each bus-power edge gives an interrupt pulse when enabled.
// (R12) Software waits 12 instructions before suspending the oscillator.
// (R13) Status bit writes are ignored and reset clears every bit.
`timescale 1ns/100ps
`default_nettype none
`include "rcr_defs.svh"

module rcr_top (
  input  wire logic       CLK,
  input  wire logic       RST,
  input  wire logic [7:0] SFR_ADDR,
  input  wire logic       SFR_WR,
  input  wire logic       SFR_RD,
  input  wire logic [7:0] SFR_WDATA,
  output var  logic [7:0] SFR_RDATA,
  input  wire logic       BUS_POWER_PIN,
  input  wire logic       BUS_POWER_IRQ_EN,
  output var  logic       BUS_POWER_IRQ,
  input  wire logic       FETCH,
  input  wire logic       PREFETCH_ON,
  input  wire logic       CLK_FAST,
  input  wire logic       EXT_CLK,
  output var  logic       MEM_POWER_ON,
  output var  logic       FETCH_STALL,
  output var  logic       INPUT_REGULATOR_DISABLE,
  output var  logic       INPUT_REGULATOR_LOW_POWER,
  output var  logic       STOP_STATE_REGULATOR_CONFIG,
  output var  logic       CORE_REGULATOR_LOW_POWER
);

  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  logic [7:0] rdata_reg;
  logic [7:0] read_value;
  logic       bus_meta_reg;
  logic       bus_sync_reg;
  logic       bus_prev_reg;
  logic       irq_reg;
  logic       hit;
  logic       wr_hit;
  logic       rd_hit;

  rcr_mpc_if mpc_link ();

  // --------------------------------------------------------------
  // decode
  // --------------------------------------------------------------
  assign hit    = (SFR_ADDR == `RCR_ADDR);
  assign wr_hit = SFR_WR && hit;
  assign rd_hit = SFR_RD && hit;

  // --------------------------------------------------------------
  // control storage
  // --------------------------------------------------------------
  // reserved bits are stored as written; only the status bit drops
  assign ctrl_next = SFR_WDATA & `RCR_WR_MASK; // R13

  always_ff @(posedge CLK)
  begin
    if (RST)
      ctrl_reg <= `RCR_RESET; // R13
    else if (wr_hit)
      ctrl_reg <= ctrl_next; // R1
  end

  assign INPUT_REGULATOR_DISABLE     = ctrl_reg[`RCR_BIT_INREG_DIS]; // R1
  assign INPUT_REGULATOR_LOW_POWER   = ctrl_reg[`RCR_BIT_INREG_LP]; // R4
  assign STOP_STATE_REGULATOR_CONFIG = ctrl_reg[`RCR_BIT_STOP_CFG]; // R5
  assign CORE_REGULATOR_LOW_POWER    = ctrl_reg[`RCR_BIT_CORE_LP]; // R6

  // --------------------------------------------------------------
  // bus-power level and edge pulse
  // --------------------------------------------------------------
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      bus_meta_reg <= 1'b0;
      bus_sync_reg <= 1'b0;
      bus_prev_reg <= 1'b0;
    end
    else
    begin
      bus_meta_reg <= BUS_POWER_PIN;
      bus_sync_reg <= bus_meta_reg;
      bus_prev_reg <= bus_sync_reg;
    end
  end

  // edge sensitive, no pending flag kept
  always_ff @(posedge CLK)
  begin
    if (RST)
      irq_reg <= 1'b0;
    else
      irq_reg <= BUS_POWER_IRQ_EN
                 && (bus_sync_reg != bus_prev_reg); // R11
  end

  assign BUS_POWER_IRQ = irq_reg;

  // --------------------------------------------------------------
  // read path
  // --------------------------------------------------------------
  always_comb
  begin
    read_value                   = ctrl_reg;
    read_value[`RCR_BIT_BUS_PWR] = bus_sync_reg; // R2
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
      rdata_reg <= `RCR_RESET;
    else if (rd_hit)
      rdata_reg <= read_value; // R2
    else
      rdata_reg <= `RCR_RESET;
  end

  assign SFR_RDATA = rdata_reg;

  // --------------------------------------------------------------
  // memory power controller
  // --------------------------------------------------------------
  assign mpc_link.enable      = ctrl_reg[`RCR_BIT_MPC_EN]; // R8
  assign mpc_link.prefetch_on = PREFETCH_ON; // R9
  assign mpc_link.fetch       = FETCH;
  assign mpc_link.clk_fast    = CLK_FAST;
  assign mpc_link.ext_clk     = EXT_CLK;

  rcr_mpc u_mpc (
    .CLK (CLK),
    .RST (RST),
    .bus (mpc_link.mpc)
  );

  assign MEM_POWER_ON = mpc_link.mem_on; // R8
  assign FETCH_STALL  = mpc_link.stall; // R10

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  a_inreg_disable_wr: assert property ( // R1
    wr_hit |=> INPUT_REGULATOR_DISABLE == $past(SFR_WDATA[`RCR_BIT_INREG_DIS]))
    else $error("input regulator disable not taken from write");

  a_status_read: assert property ( // R2
    rd_hit |=> SFR_RDATA[6] == $past(bus_sync_reg))
    else $error("status bit does not follow bus power level");

  a_inreg_lowpwr_wr: assert property ( // R4
    wr_hit |=> INPUT_REGULATOR_LOW_POWER
      == $past(SFR_WDATA[`RCR_BIT_INREG_LP]))
    else $error("input regulator mode not taken from write");

  a_stop_cfg_wr: assert property ( // R5
    wr_hit |=> STOP_STATE_REGULATOR_CONFIG
      == $past(SFR_WDATA[`RCR_BIT_STOP_CFG]))
    else $error("stop configuration not taken from write");

  a_core_lowpwr_wr: assert property ( // R6
    wr_hit |=> CORE_REGULATOR_LOW_POWER == $past(SFR_WDATA[`RCR_BIT_CORE_LP]))
    else $error("core regulator mode not taken from write");

  a_ctrl_hold: assert property ( // R1
    !wr_hit |=> ctrl_reg == $past(ctrl_reg))
    else $error("control bits changed without a write");

  a_status_ro: assert property ( // R13
    wr_hit ##1 rd_hit |=> SFR_RDATA[6] == $past(bus_sync_reg))
    else $error("write reached the status bit");

  a_irq_edge: assert property ( // R11
    BUS_POWER_IRQ_EN && $changed(bus_sync_reg) |=> BUS_POWER_IRQ)
    else $error("bus power edge gave no interrupt");

  a_irq_cause: assert property ( // R11
    BUS_POWER_IRQ |-> $past(BUS_POWER_IRQ_EN)
      && $past(bus_sync_reg) != $past(bus_prev_reg))
    else $error("interrupt without a bus power edge");

  a_reset_clear: assert property ( // R13
    disable iff (1'b0) RST |=> ctrl_reg == `RCR_RESET)
    else $error("reset left control bits set");

  c_write_all: cover property (wr_hit && SFR_WDATA[`RCR_BIT_INREG_DIS]
                               && SFR_WDATA[`RCR_BIT_MPC_EN]);
  c_irq: cover property (BUS_POWER_IRQ);
  c_read_back: cover property (wr_hit ##1 rd_hit);

endmodule : rcr_top

`default_nettype wire

// file: test/rcr_testbench.sv
// self-checking bench of the regulator control register block
`timescale 1ns/100ps
`default_nettype none

module testbench;
  logic        clk, rst, wr, rd, pin, irq_en, fetch, pref, fast, ext;
  logic [7:0]  addr, wdata, rdata;
  logic        irq, mem_on, stall, in_dis, in_lp, stop_cfg, core_lp;
  logic [15:0] rows [9];
  int          err_count;
  int          samples_checked;
  int          n;

  rcr_top i_rcr_top (
    .CLK                         (clk),
    .RST                         (rst),
    .SFR_ADDR                    (addr),
    .SFR_WR                      (wr),
    .SFR_RD                      (rd),
    .SFR_WDATA                   (wdata),
    .SFR_RDATA                   (rdata),
    .BUS_POWER_PIN               (pin),
    .BUS_POWER_IRQ_EN            (irq_en),
    .BUS_POWER_IRQ               (irq),
    .FETCH                       (fetch),
    .PREFETCH_ON                 (pref),
    .CLK_FAST                    (fast),
    .EXT_CLK                     (ext),
    .MEM_POWER_ON                (mem_on),
    .FETCH_STALL                 (stall),
    .INPUT_REGULATOR_DISABLE     (in_dis),
    .INPUT_REGULATOR_LOW_POWER   (in_lp),
    .STOP_STATE_REGULATOR_CONFIG (stop_cfg),
    .CORE_REGULATOR_LOW_POWER    (core_lp)
  );

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp,
                     input string msg);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask : chk

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wr_reg

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp, "read data");
    @(posedge clk);
    #1;
    chk(rdata, 8'h00, "read data not released");
  endtask : rd_chk

  task automatic ctl_chk(input logic [7:0] v);
    chk({4'h0, in_dis, in_lp, stop_cfg, core_lp},
        {4'h0, v[7], v[4], v[3], v[1]}, "control outputs");
  endtask : ctl_chk

  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : results

  // ---------------------------------------------------------------
  // clock and watchdog
  // ---------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial
  begin
    #(8 * 3000);
    err_count++;
    results();
  end

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial
  begin
    {rst, wr, rd, pin, irq_en, fetch, pref, fast, ext} = 9'h100;
    addr  = 8'h00;
    wdata = 8'h00;
    err_count = 0;
    samples_checked = 0;
    // written value, expected read back
    rows = '{16'h0000, 16'h9999, 16'h1B1B, 16'h8080, 16'h1010,
             16'h0808, 16'h0202, 16'h0101, 16'h4000};
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    #1;
    ctl_chk(8'h00);
    rd_chk(8'hC9, 8'h00);
    $display("reset done");
    for (int i = 0; i < 9; i++)
    begin
      wr_reg(8'hC9, rows[i][15:8]);
      ctl_chk(rows[i][7:0]);
      rd_chk(8'hC9, rows[i][7:0]);
    end
    $display("register rows done");

    wr_reg(8'hC9, 8'h10);
    wr_reg(8'hC8, 8'h99);
    ctl_chk(8'h10);
    rd_chk(8'hC9, 8'h10);
    rd_chk(8'hC8, 8'h00);
    // write then read back to back, status bit written high
    @(posedge clk);
    addr  <= 8'hC9;
    wdata <= 8'h59;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, 8'h19, "read right after write");
    ctl_chk(8'h19);
    $display("unmapped address done");

    wr_reg(8'hC9, 8'h00);
    // rising and falling edge, first enabled, then disabled
    for (int s = 0; s < 4; s++)
    begin
      @(posedge clk);
      irq_en <= !s[1];
      pin    <= !s[0];
      n = 0;
      repeat (8) @(posedge clk) #1 n += (irq === 1'b1);
      chk(n[7:0], {7'h00, !s[1]}, "pulse count per edge");
      rd_chk(8'hC9, {1'b0, !s[0], 6'h00});
    end
    $display("bus power done");

    wr_reg(8'hC9, 8'h01);
    repeat (2) @(posedge clk);
    #1;
    chk({7'h00, mem_on}, 8'h00, "memory on without fetch");
    fetch <= 1'b1;
    @(posedge clk);
    #1;
    chk({7'h00, mem_on}, 8'h01, "memory off on fetch");
    fetch <= 1'b0;
    pref  <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk({7'h00, mem_on}, 8'h01, "memory off with prefetch");
    pref <= 1'b0;
    for (int e = 0; e < 2; e++)
    begin
      ext <= e[0];
      repeat (2) @(posedge clk);
      fast <= 1'b1;
      n = 0;
      repeat (30) @(posedge clk)
      begin
        #1;
        if (stall === 1'b1)
        begin
          n++;
          chk({7'h00, mem_on}, 8'h01, "memory off in skip");
        end
      end
      chk(n[7:0], e ? 8'h14 : 8'h00, "skip window length");
      fast <= 1'b0;
    end
    wr_reg(8'hC9, 8'h00);
    @(posedge clk);
    #1;
    chk({7'h00, mem_on}, 8'h01, "memory off with controller off");
    $display("memory power done");

    wr_reg(8'hC9, 8'h99);
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    #1;
    ctl_chk(8'h00);
    chk({6'h00, mem_on, stall}, 8'h02, "memory outputs after reset");
    rd_chk(8'hC9, 8'h00);
    $display("mid-run reset done");
    results();
  end
endmodule : testbench

`default_nettype wire
